// file: design/sts_pkg.sv
// Shared constants, types and helpers of the sweep sequencer
package sts_pkg;

  localparam logic [7:0]  CLK_NS    = 8'h32;
  localparam logic [7:0]  STEP_NS   = 8'h7D;
  localparam longint      MAX_T_NS  = 64'h0000_0017_4876_E800;
  localparam logic [29:0] MAX_STEPS = 30'(MAX_T_NS / 64'(STEP_NS));
  localparam logic [29:0] MIN_STEPS = 30'h0000_0001;

  localparam logic [14:0] COUNT_RST = 15'h0000;
  localparam logic [14:0] COUNT_MAX = 15'h7FFF;
  localparam logic [14:0] AVG_RUN   = 15'h000A;
  localparam logic [13:0] PTS_DEF   = 14'h0271;
  localparam logic [9:0]  PRE_NUM   = 10'h1F3;
  localparam logic [9:0]  PRE_DIV   = 10'h1F4;
  localparam logic [6:0]  VID_MAX   = 7'h64;
  localparam logic [6:0]  VID_RST   = 7'h32;
  localparam logic signed [7:0] IFP_MIN = 8'shE2;
  localparam logic signed [7:0] IFP_MAX = 8'shF6;

  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CMD   = 8'h04;
  localparam logic [7:0] A_COUNT = 8'h08;
  localparam logic [7:0] A_PTS   = 8'h0C;
  localparam logic [7:0] A_OFS   = 8'h10;
  localparam logic [7:0] A_GDLY  = 8'h14;
  localparam logic [7:0] A_GLEN  = 8'h18;
  localparam logic [7:0] A_VLVL  = 8'h1C;
  localparam logic [7:0] A_ILVL  = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  localparam logic [7:0] A_AVG   = 8'h28;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_SLV = 2'h2;
  localparam logic [1:0] RESP_DEC = 2'h3;

  typedef enum logic [1:0] {
    MODE_CONT = 2'b00, MODE_SINGLE = 2'b01, MODE_BLANK = 2'b10,
    MODE_RSVD = 2'b11 } sts_mode_e;
  typedef enum logic [1:0] {
    SRC_FREE = 2'b00, SRC_VIDEO = 2'b01, SRC_REAR = 2'b10,
    SRC_IFP = 2'b11 } sts_src_e;
  typedef enum logic [1:0] {
    DET_PEAK = 2'b00, DET_AUTOPK = 2'b01, DET_RMS = 2'b10,
    DET_AVG = 2'b11 } sts_det_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ARM = 2'b01, ST_DELAY = 2'b10,
    ST_RUN = 2'b11 } sts_state_e;
  typedef enum logic [1:0] {
    GPH_SHUT = 2'b00, GPH_WAIT = 2'b01, GPH_OPEN = 2'b10 } sts_gph_e;

  typedef struct packed {
    logic [20:0] rsvd;
    sts_det_e    det;
    logic        zero_span;
    logic        dual;
    logic        gate_edge;
    logic        gate_en;
    logic        neg_pol;
    sts_src_e    src;
    sts_mode_e   mode;
  } sts_ctrl_s;

  localparam sts_ctrl_s CTRL_RST = '0;

  function automatic logic [31:0] strb_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction : strb_merge

  function automatic logic pts_ok(input logic [31:0] v);
    return v inside {32'h9B, 32'h139, 32'h271, 32'h4E3, 32'h9C5,
                     32'h1389, 32'h2711};
  endfunction : pts_ok

  function automatic logic [13:0] pre_limit(input logic [13:0] p);
    logic [23:0] m;
    m = 24'(p) * 24'(PRE_NUM);
    return 14'(m / 24'(PRE_DIV));
  endfunction : pre_limit

  function automatic logic avg_det(input sts_det_e d);
    return d == DET_RMS || d == DET_AVG;
  endfunction : avg_det

  function automatic logic gate_src(input sts_src_e s);
    return s == SRC_REAR || s == SRC_IFP;
  endfunction : gate_src

endpackage : sts_pkg

// file: design/sts_step_tick.sv
// Fractional divider giving one pulse per 125 ns time step
`timescale 1ns/1ps
module sts_step_tick
  import sts_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  logic [7:0] acc_q;
  logic [7:0] sum;

  // Step is not a whole number of cycles, so pulses alternate 2 and 3 apart
  assign sum = acc_q + CLK_NS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 8'h00;
      tick  <= 1'b0;
    end else if (sum >= STEP_NS) begin
      acc_q <= sum - STEP_NS;
      tick  <= 1'b1;
    end else begin
      acc_q <= sum;
      tick  <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> !tick ##1 (tick or (!tick ##1 tick)))
    else $error("step ticks not two or three cycles apart");

endmodule : sts_step_tick

// file: design/sts_sweep_seq.sv
// Sweep sequencer: register slave, trigger, gate and pass control
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module sts_sweep_seq
  import sts_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rear_trigger_gate_input,
  input  wire logic [6:0]        displayed_level,
  input  wire logic signed [7:0] ifp_level_dbm,
  input  wire logic              ifp_in_band,
  output logic                   acq_enable,
  output logic                   sample_strobe,
  output logic [13:0]            sample_index,
  output logic                   pass_start,
  output logic                   pass_done,
  output logic                   trace_clear,
  output logic                   display_enable,
  output logic                   window_sel,
  output logic [1:0]             triggered_indicator,
  output logic                   peak_det_allow,
  output logic [14:0]            avg_length,
  output logic                   seq_done
);
  sts_ctrl_s         ctrl_q, nctrl;
  sts_state_e        state_q;
  sts_gph_e          gph_q;
  logic [14:0]       count_q, pass_cnt_q;
  logic [13:0]       points_q, samp_q, pre_eff, lim;
  logic [31:0]       offset_q, cur_mag, ofs_mag, wcur, wv, rd_val;
  logic [29:0]       gdly_q, glen_q, dly_q, gcnt_q;
  logic [6:0]        vthr_q;
  logic signed [7:0] ithr_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_hold_q, w_hold_q, wr_fire, wmap, wlegal, wr_ok;
  logic              restart, resume, abort, st_clr;
  logic              tick, lvl, pl, prev_q, edge_hit, gate_open;
  logic              last_samp, last_pass, pass_end, win_end, fin;
  logic              start_ok, blank_q;

  sts_step_tick u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // Write channel: address and data caught separately, one write at a time
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_ok         = wr_fire && wmap && wlegal;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= !wmap ? RESP_DEC : (!wlegal ? RESP_SLV : RESP_OK);
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awaddr_q)
      A_CTRL:  wcur = ctrl_q;
      A_COUNT: wcur = {17'h0, count_q};
      A_PTS:   wcur = {18'h0, points_q};
      A_OFS:   wcur = offset_q;
      A_GDLY:  wcur = {2'h0, gdly_q};
      A_GLEN:  wcur = {2'h0, glen_q};
      A_VLVL:  wcur = {25'h0, vthr_q};
      A_ILVL:  wcur = {{24{ithr_q[7]}}, ithr_q};
      default: wcur = 32'h0000_0000;
    endcase
  end

  assign wv      = strb_merge(wcur, wdata_q, wstrb_q);
  assign ofs_mag = wv[31] ? 32'h0 - wv : wv;
  assign lim     = pre_limit(points_q);

  // Illegal writes leave the register alone and answer SLVERR; unmapped ones answer DECERR
  always_comb begin
    wmap   = 1'b1;
    wlegal = 1'b1;
    nctrl  = sts_ctrl_s'(wv);
    nctrl.rsvd = 21'h0;
    case (awaddr_q)
      A_CTRL: begin
        if (nctrl.gate_en && !gate_src(nctrl.src)) nctrl.src = SRC_IFP;
      end
      A_COUNT: wlegal = wv[31:15] == 17'h0;
      A_PTS:   wlegal = pts_ok(wv);
      A_OFS: begin
        wlegal = ofs_mag <= {2'h0, MAX_STEPS} &&
                 (!wv[31] || (ctrl_q.zero_span && !ctrl_q.gate_en &&
                  !avg_det(ctrl_q.det) &&
                  ofs_mag <= {18'h0, lim}));
      end
      A_GDLY, A_GLEN: begin
        wlegal = wv >= {2'h0, MIN_STEPS} && wv <= {2'h0, MAX_STEPS};
      end
      A_VLVL:  wlegal = wv <= {25'h0, VID_MAX};
      A_ILVL: begin
        wlegal = (wv[31:7] == 25'h0 || wv[31:7] == 25'h1FF_FFFF) &&
                 $signed(wv[7:0]) >= IFP_MIN &&
                 $signed(wv[7:0]) <= IFP_MAX;
      end
      A_CMD, A_STAT: wlegal = 1'b1;
      default: wmap = 1'b0;
    endcase
  end

  assign restart = wr_ok && (awaddr_q == A_CTRL ||
                   (awaddr_q == A_CMD && wv[0]));
  assign resume  = wr_ok && awaddr_q == A_CMD && wv[1];
  assign abort   = wr_ok && awaddr_q == A_CMD && wv[2];
  assign st_clr  = wr_ok && awaddr_q == A_STAT && wv[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= CTRL_RST;
      count_q  <= COUNT_RST;
      points_q <= PTS_DEF;
      offset_q <= 32'h0000_0000;
      gdly_q   <= MIN_STEPS;
      glen_q   <= MIN_STEPS;
      vthr_q   <= VID_RST;
      ithr_q   <= IFP_MIN;
    end else if (wr_ok) begin
      case (awaddr_q)
        A_CTRL: begin
          ctrl_q <= nctrl;
          // A setting change that forbids pretrigger drops it to zero
          if (offset_q[31] && !(nctrl.zero_span && !nctrl.gate_en &&
              !avg_det(nctrl.det))) offset_q <= 32'h0;
        end
        A_COUNT: count_q  <= wv[14:0];
        A_PTS:   points_q <= wv[13:0];
        A_OFS:   offset_q <= wv;
        A_GDLY: begin
          gdly_q <= wv[29:0];
          if (gate_src(ctrl_q.src)) offset_q <= {2'h0, wv[29:0]};
        end
        A_GLEN:  glen_q <= wv[29:0];
        A_VLVL:  vthr_q <= wv[6:0];
        A_ILVL:  ithr_q <= wv[7:0];
        default: ;
      endcase
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    case ({s_axi_araddr[7:2], 2'b00})
      A_CTRL:  rd_val = ctrl_q;
      A_COUNT: rd_val = {17'h0, count_q};
      A_PTS:   rd_val = {18'h0, points_q};
      A_OFS:   rd_val = offset_q;
      A_GDLY:  rd_val = {2'h0, gdly_q};
      A_GLEN:  rd_val = {2'h0, glen_q};
      A_VLVL:  rd_val = {25'h0, vthr_q};
      A_ILVL:  rd_val = {{24{ithr_q[7]}}, ithr_q};
      A_STAT:  rd_val = {1'b0, pass_cnt_q, 10'h0, peak_det_allow,
                         triggered_indicator, window_sel,
                         state_q != ST_IDLE, seq_done};
      A_AVG:   rd_val = {17'h0, avg_length};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= (s_axi_araddr[7:2] > A_AVG[7:2] ||
                       {s_axi_araddr[7:2], 2'b00} == A_CMD) ?
                      RESP_DEC : RESP_OK;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Trigger level of the chosen source; the rear pin is TTL, clock-aligned
  always_comb begin
    unique case (ctrl_q.src)
      SRC_FREE:  lvl = 1'b1;
      SRC_VIDEO: lvl = displayed_level >= vthr_q;
      SRC_REAR:  lvl = rear_trigger_gate_input;
      SRC_IFP:   lvl = ifp_in_band && ifp_level_dbm > ithr_q;
    endcase
  end

  assign pl       = lvl ^ ctrl_q.neg_pol;
  assign edge_hit = pl && !prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prev_q <= 1'b1;
    else        prev_q <= pl;
  end

  // Gate: wait phase counts the delay, open phase the edge-mode length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gph_q  <= GPH_SHUT;
      gcnt_q <= 30'h0;
    end else if (!ctrl_q.gate_en) begin
      gph_q  <= GPH_SHUT;
      gcnt_q <= 30'h0;
    end else if (!ctrl_q.gate_edge && !pl) begin
      gph_q  <= GPH_SHUT;
      gcnt_q <= 30'h0;
    end else begin
      case (gph_q)
        GPH_SHUT: begin
          if (ctrl_q.gate_edge ? edge_hit : pl) gph_q <= GPH_WAIT;
          gcnt_q <= 30'h0;
        end
        GPH_WAIT: if (tick) begin
          if (gcnt_q == gdly_q - 30'h1) begin
            gph_q  <= GPH_OPEN;
            gcnt_q <= 30'h0;
          end else gcnt_q <= gcnt_q + 30'h1;
        end
        GPH_OPEN: if (tick && ctrl_q.gate_edge) begin
          if (gcnt_q == glen_q - 30'h1) gph_q <= GPH_SHUT;
          else gcnt_q <= gcnt_q + 30'h1;
        end
        default: gph_q <= GPH_SHUT;
      endcase
    end
  end

  assign gate_open = !ctrl_q.gate_en || gph_q == GPH_OPEN;

  // Pretrigger depth, clipped again in case the point count shrank
  assign cur_mag = 32'h0 - offset_q;
  assign pre_eff = !offset_q[31] ? 14'h0 :
                   (cur_mag[13:0] > lim ? lim : cur_mag[13:0]);

  // Point count shrunk mid-pass ends the pass instead of wrapping
  assign last_samp = samp_q >= points_q - 14'h1;
  assign last_pass = {1'b0, pass_cnt_q} + 16'h1 >=
                     (count_q == 15'h0 ? 16'h1 : {1'b0, count_q});
  assign pass_end  = state_q == ST_RUN && tick && gate_open && last_samp;
  assign win_end   = pass_end && (!ctrl_q.dual || window_sel);
  assign fin       = win_end && ctrl_q.mode != MODE_CONT && last_pass;
  assign start_ok  = samp_q == pre_eff && (ctrl_q.gate_en ||
                     ctrl_q.src == SRC_FREE || edge_hit);

  // Pretrigger fills from arming; it is not a rolling window of history
  assign acq_enable    = (state_q == ST_RUN && gate_open) ||
                         (state_q == ST_ARM && samp_q < pre_eff);
  assign sample_strobe = acq_enable && tick;
  assign sample_index  = samp_q;
  assign display_enable = !blank_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_ARM;
      samp_q      <= 14'h0;
      dly_q       <= 30'h0;
      pass_cnt_q  <= 15'h0;
      window_sel  <= 1'b0;
      blank_q     <= 1'b0;
      trace_clear <= 1'b0;
      pass_start  <= 1'b0;
      pass_done   <= 1'b0;
    end else begin
      trace_clear <= 1'b0;
      pass_start  <= 1'b0;
      pass_done   <= 1'b0;
      if (abort) begin
        state_q <= ST_IDLE;
        blank_q <= 1'b0;
      end else if (restart || (resume && ctrl_q.mode != MODE_CONT)) begin
        state_q     <= ST_ARM;
        samp_q      <= 14'h0;
        pass_cnt_q  <= 15'h0;
        window_sel  <= 1'b0;
        blank_q     <= (restart ? nctrl.mode : ctrl_q.mode) ==
                       MODE_BLANK;
        trace_clear <= restart;
      end else begin
        unique case (state_q)
          ST_IDLE: ;
          ST_ARM: begin
            if (tick && samp_q < pre_eff) samp_q <= samp_q + 14'h1;
            else if (start_ok) begin
              pass_start <= 1'b1;
              dly_q      <= 30'h0;
              if (!offset_q[31] && offset_q != 32'h0)
                state_q <= ST_DELAY;
              else state_q <= ST_RUN;
            end
          end
          ST_DELAY: if (tick) begin
            if (dly_q == offset_q[29:0] - 30'h1) state_q <= ST_RUN;
            else dly_q <= dly_q + 30'h1;
          end
          ST_RUN: if (tick && gate_open) begin
            if (last_samp) begin
              pass_done <= 1'b1;
              samp_q    <= 14'h0;
              state_q   <= ST_ARM;
              if (!win_end) window_sel <= 1'b1;
              else begin
                window_sel <= 1'b0;
                if (pass_cnt_q != COUNT_MAX)
                  pass_cnt_q <= pass_cnt_q + 15'h1;
                if (fin) begin
                  state_q <= ST_IDLE;
                  blank_q <= 1'b0;
                end
              end
            end else samp_q <= samp_q + 14'h1;
          end
        endcase
      end
    end
  end

  // Completion flag: a finish in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)      seq_done <= 1'b0;
    else if (fin && !abort && !restart) seq_done <= 1'b1;
    else if (st_clr) seq_done <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peak_det_allow      <= 1'b1;
      triggered_indicator <= 2'b00;
      avg_length          <= 15'h0;
    end else begin
      peak_det_allow <= points_q == PTS_DEF;
      triggered_indicator <= {ctrl_q.dual && ctrl_q.src != SRC_FREE,
                              ctrl_q.src != SRC_FREE};
      if (count_q == 15'h0)
        avg_length <= ctrl_q.mode == MODE_CONT ? AVG_RUN : 15'h0;
      else if (count_q == 15'h1) avg_length <= 15'h0;
      else avg_length <= count_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_gate_source: assert property (ctrl_q.gate_en |->
    gate_src(ctrl_q.src)) else $error("gating with unfit source");
  a_points_legal: assert property (pts_ok({18'h0, points_q}))
    else $error("illegal samples per pass");
  a_peak_allow: assert property ((points_q != PTS_DEF &&
    $stable(points_q)) |-> !peak_det_allow)
    else $error("peak detector allowed off default points");
  a_free_start: assert property ((state_q == ST_ARM &&
    ctrl_q.src == SRC_FREE && !ctrl_q.gate_en && offset_q == 32'h0 &&
    !wr_ok) |=> state_q == ST_RUN && pass_start)
    else $error("untriggered pass did not start at once");
  a_single_halt: assert property ((fin && !wr_ok) |=>
    state_q == ST_IDLE && seq_done && pass_done)
    else $error("one-shot did not halt");
  a_blank_disp: assert property ((state_q != ST_IDLE &&
    ctrl_q.mode == MODE_BLANK) |-> !display_enable)
    else $error("display shown during blanked pass");
  a_neg_offset: assert property (offset_q[31] |->
    ctrl_q.zero_span && !ctrl_q.gate_en && !avg_det(ctrl_q.det))
    else $error("pretrigger held where forbidden");
  a_gate_pause: assert property ((ctrl_q.gate_en &&
    gph_q != GPH_OPEN) |-> !acq_enable && !sample_strobe)
    else $error("acquired while gate closed");
  a_done_hold: assert property ((seq_done && !st_clr) |=>
    seq_done) else $error("completion flag lost");
  a_gdly_link: assert property ((wr_ok && awaddr_q == A_GDLY &&
    gate_src(ctrl_q.src)) |=> offset_q == {2'h0, $past(wv[29:0])})
    else $error("gate delay did not set offset");

  c_single_done: cover property (fin ##1 seq_done);
  c_pretrig:     cover property (pass_start && samp_q != 14'h0);
  c_gate_open:   cover property (gph_q == GPH_OPEN && sample_strobe);

endmodule : sts_sweep_seq

// file: sim/sts_ttl_src.sv
// Behavioural TTL trigger and gate source on the rear input
`timescale 1ns/1ps
module sts_ttl_src (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic want_high,
  output logic      ttl_out
);
  // Full logic levels only, changed just after a clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ttl_out <= 1'b0;
    else ttl_out <= want_high;
  end
endmodule : sts_ttl_src

// file: sim/tb_sts_sweep_seq.sv
// Register-level regression of the sweep sequencer
`timescale 1ns/1ps
module tb_sts_sweep_seq;
  import sts_pkg::*;
  logic        clk = 0, rst_n = 0, want = 0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, d;
  logic        awready, wready, bvalid, arready, rvalid, pin;
  logic        pstart, pdone, tclr, pk, done, disp, strb;
  logic [1:0]  bresp, rresp, trig, r;
  logic [14:0] avg;
  int          fail_count = 0, compares = 0, cyc = 0, t;
  int          n_done = 0, n_start = 0, n_clr = 0, n_strb = 0;

  sts_ttl_src u_src (.clk(clk), .rst_n(rst_n), .want_high(want),
    .ttl_out(pin));

  sts_sweep_seq dut (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rear_trigger_gate_input(pin),
    .displayed_level(7'h00), .ifp_level_dbm(8'sh80), .ifp_in_band(1'b0),
    .acq_enable(), .sample_strobe(strb), .sample_index(),
    .pass_start(pstart),
    .pass_done(pdone), .trace_clear(tclr), .display_enable(disp),
    .window_sel(), .triggered_indicator(trig), .peak_det_allow(pk),
    .avg_length(avg), .seq_done(done));

  initial begin
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // Pulses counted mid-cycle, where they are settled
  always @(negedge clk) begin
    if (pdone === 1'b1) n_done++;
    if (pstart === 1'b1) n_start++;
    if (tclr === 1'b1) n_clr++;
    if (strb === 1'b1) n_strb++;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      fail_count++;
    end
  endtask : chk

  // Handshakes judged at negedge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    logic ah, wh, bh;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end while (!bh);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ah, rh;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ah = arvalid & arready;
      rh = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end while (!rh);
  endtask : rd

  // One more negedge so the pulse counters have seen the final pass
  task automatic wait_done;
    for (int i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
  endtask : wait_done

  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    wait (rst_n === 1'b1);
    repeat (2) @(negedge clk);
    chk(32'(avg), 32'hA);
    chk(32'(pk), 32'h1);
    rd(A_PTS, d, r);
    chk(d, 32'h271);
    rd(8'h2C, d, r);
    chk(32'(r), 32'(RESP_DEC));
    wr(A_PTS, 32'h64, r);
    chk(32'(r), 32'(RESP_SLV));
    wr(A_PTS, 32'h9B, r);
    chk(32'(r), 32'(RESP_OK));
    @(negedge clk);
    chk(32'(pk), 32'h0);
    wr(A_COUNT, 32'h8000, r);
    chk(32'(r), 32'(RESP_SLV));
    wr(A_OFS, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'(RESP_SLV));
    wr(A_COUNT, 32'h2, r);
    t = n_clr;
    wr(A_CTRL, 32'h0, r);
    repeat (3) @(negedge clk);
    chk(32'(n_clr - t), 32'h1);
    t = n_done;
    wr(A_CTRL, 32'h1, r);
    wait_done();
    chk(32'(done), 32'h1);
    chk(32'(n_done - t), 32'h2);
    t = n_done;
    repeat (300) @(negedge clk);
    chk(32'(n_done - t), 32'h0);
    rd(A_STAT, d, r);
    chk(32'(d[0]), 32'h1);
    wr(A_CTRL, 32'h8, r);
    @(negedge clk);
    chk(32'(trig), 32'h1);
    t = n_start;
    repeat (40) @(negedge clk);
    chk(32'(n_start - t), 32'h0);
    @(posedge clk);
    want <= 1'b1;
    repeat (10) @(negedge clk);
    chk(32'(n_start - t), 32'h1);
    wr(A_VLVL, 32'h65, r);
    chk(32'(r), 32'(RESP_SLV));
    wr(A_ILVL, 32'hFFFF_FFE1, r);
    chk(32'(r), 32'(RESP_SLV));
    wr(A_STAT, 32'h1, r);
    wr(A_CTRL, 32'h2, r);
    t = n_strb;
    @(negedge clk);
    chk(32'(done), 32'h0);
    chk(32'(disp), 32'h0);
    wait_done();
    chk(32'(disp), 32'h1);
    chk(32'(n_strb - t), 32'd310);
    wr(A_STAT, 32'h1, r);
    t = n_clr;
    wr(A_CMD, 32'h2, r);
    @(negedge clk);
    chk(32'(disp), 32'h0);
    wait_done();
    chk(32'(n_clr - t), 32'h0);
    chk(32'(done), 32'h1);
    wr(A_STAT, 32'h1, r);
    t = n_done;
    wr(A_CTRL, 32'h81, r);
    wait_done();
    chk(32'(n_done - t), 32'h4);
    end_of_test();
  end
endmodule : tb_sts_sweep_seq
